// [rtl/rtss_params.svh]
/*
 * Constants for the reset and test strap sampling block.
 * Assumes a 10 MHz core clock and inclusion by bare name.
 */
`ifndef RTSS_PARAMS_SVH
`define RTSS_PARAMS_SVH
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define RTSS_CLK_PERIOD_NS 100
`define RTSS_STRAP_DELAY_NS 1500
`define RTSS_STRAP_CYCLES ((`RTSS_STRAP_DELAY_NS) / (`RTSS_CLK_PERIOD_NS))
`define RTSS_CNT_W 5
// ------------------------------------------------------------
// Widths and reset values
// ------------------------------------------------------------
`define RTSS_STRAP_W 8
`define RTSS_STRAP_ZERO 8'h00
`define RTSS_STRAP_ONES 8'hFF
`define RTSS_BIT_CLR 1'h0
`define RTSS_BIT_SET 1'h1
`define RTSS_SYNC_RST 3'h0
`endif

// [rtl/rtss_pkg.sv]
/*
 * Types for the reset and test strap sampling block.
 * Assumes rtss_params.svh is available on the include path.
 */
`include "rtss_params.svh"
package rtss_pkg;
    // --------------------------------------------------------
    // Sequencer states
    // --------------------------------------------------------
    typedef enum logic [1:0] {
        RTSS_HOLD = 2'b00,
        RTSS_WAIT = 2'b01,
        RTSS_RUN = 2'b10
    } rtss_state_type;
    typedef logic [`RTSS_STRAP_W-1:0] rtss_strap_type;
endpackage : rtss_pkg

// [rtl/rtss_top.sv]
/*
 * Power-on reset sequencing with test strap sampling: holds every output
 * inactive while the reset pad is low, waits a fixed count after release,
 * samples the eight strap pads, latches the test mode choice and then
 * turns the strap pins into driven outputs.
 * Assumes a stable 10 MHz CLK and pad cells that combine OE and data.
 * Assumes the reset pad only rises once supplies and clocks are steady.
 */
`timescale 1ns/10ps
`include "rtss_params.svh"
module rtss_top (
    input wire logic CLK,
    input wire logic RST,
    input wire logic POWER_ON_RESET_N,
    input wire rtss_pkg::rtss_strap_type TEST_STRAP_PIN_IN,
    input wire rtss_pkg::rtss_strap_type TEST_STRAP_PIN_DATA,
    output logic [`RTSS_STRAP_W-1:0] TEST_STRAP_PIN_OUT,
    output logic [`RTSS_STRAP_W-1:0] TEST_STRAP_PIN_OE,
    output logic [`RTSS_STRAP_W-1:0] TEST_MODE_SELECT,
    output logic TEST_MODE,
    output logic CONFIG_START,
    output logic CONFIG_ACTIVE
);
    import rtss_pkg::*;

    // --------------------------------------------------------
    // Timing at a glance
    // --------------------------------------------------------
    // A rise on the reset pad is accepted four edges later, once the
    // synchroniser's last two stages agree. One more edge moves the
    // sequencer into its wait, which then counts RTSS_STRAP_CYCLES
    // edges before the strap sample is latched. The sample therefore
    // lands a few cycles after the nominal point, well inside the
    // loose timing the strap pins allow.
    // A low dip on the pad lasting a single clock never reaches the
    // accepted level, so a noisy supervisor cannot restart the wait.
    // A dip of two clocks or more is a real reset and drops every
    // output within five edges.
    // Configuration start is a single-cycle pulse.

    // --------------------------------------------------------
    // Reset pin synchroniser
    // --------------------------------------------------------
    logic [2:0] por_sync;
    logic [2:0] next_por_sync;
    logic por_level;
    logic next_por_level;

    // Shift in the pad; level moves only when stages two and three agree
    always_comb begin
        next_por_sync = {por_sync[1:0], POWER_ON_RESET_N};
        next_por_level = por_level;
        if (por_sync[1] == por_sync[2]) begin
            next_por_level = por_sync[2];
        end
    end

    // Register only; a cleared chain reads as reset still held
    always_ff @(posedge CLK) begin
        if (RST) begin
            por_sync <= `RTSS_SYNC_RST;
            por_level <= `RTSS_BIT_CLR;
        end else begin
            por_sync <= next_por_sync;
            por_level <= next_por_level;
        end
    end

    // --------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------
    rtss_state_type state;
    rtss_state_type next_state;
    // Count width covers the strap wait with room to spare
    logic [`RTSS_CNT_W-1:0] cnt;
    logic [`RTSS_CNT_W-1:0] next_cnt;
    rtss_strap_type mode_sel;
    rtss_strap_type next_mode_sel;
    logic next_start;
    wire rtss_strap_type strap_level;

    // --------------------------------------------------------
    // Strap pin synchronisers
    // --------------------------------------------------------
    // Each strap pad gets its own three-stage chain. A bit only moves
    // once stages two and three agree, so a pad still settling on its
    // weak pulldown cannot leak a half-resolved bit into the sample.
    // The latency is harmless: the straps sit still long before use.
    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < `RTSS_STRAP_W; bit_idx++) begin : g_strap
            logic [2:0] chain;
            logic [2:0] next_chain;
            logic level;
            logic next_level;

            // Shift in the pad; hold the level while the stages disagree
            always_comb begin
                next_chain = {chain[1:0], TEST_STRAP_PIN_IN[bit_idx]};
                next_level = level;
                if (chain[1] == chain[2]) begin
                    next_level = chain[2];
                end
            end

            // Register only; reset parks the chain at the pulldown level
            always_ff @(posedge CLK) begin
                if (RST) begin
                    chain <= `RTSS_SYNC_RST;
                    level <= `RTSS_BIT_CLR;
                end else begin
                    chain <= next_chain;
                    level <= next_level;
                end
            end

            assign strap_level[bit_idx] = level;
        end
    endgenerate

    // Low reset forces HOLD from any state, so outputs fall at once,
    // and every new release replays the full wait from a zero count.
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_mode_sel = mode_sel;
        next_start = `RTSS_BIT_CLR;
        if (!por_level) begin
            next_state = RTSS_HOLD;
            next_cnt = '0;
            next_mode_sel = `RTSS_STRAP_ZERO;
        end else begin
            unique case (state)
                RTSS_HOLD: begin
                    // Level has just risen: restart the wait
                    next_state = RTSS_WAIT;
                    next_cnt = '0;
                end
                RTSS_WAIT: begin
                    next_cnt = cnt + 1'b1;
                    // Last count: latch the straps, start configuring
                    if (cnt == `RTSS_CNT_W'(`RTSS_STRAP_CYCLES - 1)) begin
                        next_mode_sel = strap_level;
                        next_state = RTSS_RUN;
                        next_start = `RTSS_BIT_SET;
                    end
                end
                RTSS_RUN: begin
                    // Straps are ignored until the pad drops again
                    next_mode_sel = mode_sel;
                end
                default: begin
                    next_state = RTSS_HOLD;
                end
            endcase
        end
    end

    // Register only
    always_ff @(posedge CLK) begin
        if (RST) begin
            state <= RTSS_HOLD;
            cnt <= '0;
            mode_sel <= `RTSS_STRAP_ZERO;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            mode_sel <= next_mode_sel;
        end
    end

    // --------------------------------------------------------
    // Output registers
    // --------------------------------------------------------
    logic [`RTSS_STRAP_W-1:0] next_pin_oe;
    logic [`RTSS_STRAP_W-1:0] next_pin_out;
    logic next_test_mode;
    logic next_active;

    // Pins float until the strap sample is taken, then carry test data.
    // Looking at next_state keeps the drive change in step with the
    // sample, so the pads never float for a cycle after selection
    // and never drive before the straps have been read.
    always_comb begin
        next_pin_oe = `RTSS_STRAP_ZERO;
        next_pin_out = `RTSS_STRAP_ZERO;
        next_test_mode = |next_mode_sel;
        next_active = `RTSS_BIT_CLR;
        if (next_state == RTSS_RUN) begin
            next_pin_oe = `RTSS_STRAP_ONES;
            next_pin_out = TEST_STRAP_PIN_DATA;
            next_active = `RTSS_BIT_SET;
        end
    end

    // Register only; every top-level output leaves a flip-flop
    always_ff @(posedge CLK) begin
        if (RST) begin
            TEST_STRAP_PIN_OE <= `RTSS_STRAP_ZERO;
            TEST_STRAP_PIN_OUT <= `RTSS_STRAP_ZERO;
            TEST_MODE_SELECT <= `RTSS_STRAP_ZERO;
            TEST_MODE <= `RTSS_BIT_CLR;
            CONFIG_START <= `RTSS_BIT_CLR;
            CONFIG_ACTIVE <= `RTSS_BIT_CLR;
        end else begin
            TEST_STRAP_PIN_OE <= next_pin_oe;
            TEST_STRAP_PIN_OUT <= next_pin_out;
            TEST_MODE_SELECT <= next_mode_sel;
            TEST_MODE <= next_test_mode;
            CONFIG_START <= next_start;
            CONFIG_ACTIVE <= next_active;
        end
    end
endmodule : rtss_top

// [verification/rtss_checker.sv]
/* Port checker for rtss_top. Assumes bind from the bench top. */
`timescale 1ns/10ps
module rtss_checker (
    input wire logic CLK,
    input wire logic RST,
    input wire logic POWER_ON_RESET_N,
    input wire rtss_pkg::rtss_strap_type TEST_STRAP_PIN_OE,
    input wire rtss_pkg::rtss_strap_type TEST_STRAP_PIN_OUT,
    input wire rtss_pkg::rtss_strap_type TEST_MODE_SELECT,
    input wire logic TEST_MODE,
    input wire logic CONFIG_START,
    input wire logic CONFIG_ACTIVE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // Six low samples clear the pad synchroniser
    sequence por_low_s; !POWER_ON_RESET_N [*6]; endsequence
    chk_hold_idle:
    assert property (por_low_s |-> !CONFIG_ACTIVE && TEST_STRAP_PIN_OE == 8'h00)
        else $error("outputs active in reset");
    chk_start_bound:
    assert property ($rose(POWER_ON_RESET_N) |->
        ##[1:25] (CONFIG_ACTIVE || !POWER_ON_RESET_N)) else $error("no start");
    chk_start_late:
    assert property ($rose(CONFIG_START) |-> $past(POWER_ON_RESET_N, 15))
        else $error("sample too early");
    chk_start_pulse:
    assert property (CONFIG_START |=> !CONFIG_START) else $error("long start");
    chk_drive_on:
    assert property (CONFIG_START |-> TEST_STRAP_PIN_OE == 8'hFF && CONFIG_ACTIVE)
        else $error("pins not driven");
    chk_mode_or:
    assert property (CONFIG_ACTIVE |-> TEST_MODE == (|TEST_MODE_SELECT))
        else $error("mode wrong");
    chk_idle_quiet:
    assert property (!CONFIG_ACTIVE |-> TEST_STRAP_PIN_OUT == 8'h00 &&
        TEST_STRAP_PIN_OE == 8'h00 && !TEST_MODE && !CONFIG_START &&
        TEST_MODE_SELECT == 8'h00) else $error("idle outputs active");
    chk_sel_hold:
    assert property (CONFIG_ACTIVE && $past(CONFIG_ACTIVE) |->
        $stable(TEST_MODE_SELECT)) else $error("selection moved");
endmodule : rtss_checker

// [verification/rtss_pmic.sv]
/* Power manager model. Assumes the bench gives the strap pull-ups. */
`timescale 1ns/10ps
module rtss_pmic (
    input wire logic clk,
    input wire logic hold,
    input wire rtss_pkg::rtss_strap_type pull_up,
    input wire rtss_pkg::rtss_strap_type oe,
    input wire rtss_pkg::rtss_strap_type dout,
    output logic por_n,
    output rtss_pkg::rtss_strap_type pad
);
    // Release only on an edge, so the clock is known to run
    initial por_n = 1'b0;
    always @(posedge clk) por_n <= !hold;
    // The scan port reset is strapped low on the board and the reserved
    // scan pins get no net at all; the block has no pins for them
    // Undriven pads sit on the weak pulldown unless strapped high
    assign pad = (oe & dout) | (~oe & pull_up);
endmodule : rtss_pmic

// [verification/rtss_tb_top.sv]
/* Bench top: boots the block with several straps. No other files. */
`timescale 1ns/10ps
`define CHK(n, e, a) check_count++; if ((a) !== (e)) begin error_cnt++; \
    $display("wrong value %s exp %h got %h", n, e, a); end
module rtss_tb_top;
    import rtss_pkg::*;
    logic clk = 0, rst = 1, hold = 1, por_n, mode, start, act;
    rtss_strap_type pull = 8'h00, data = 8'hA5, pad, dout, oe, sel;
    int error_cnt = 0;
    int check_count = 0;
    always #50 clk = ~clk;
    rtss_pmic u_pmic (.clk(clk), .hold(hold), .pull_up(pull), .oe(oe),
        .dout(dout), .por_n(por_n), .pad(pad));
    rtss_top u_dut (.CLK(clk), .RST(rst), .POWER_ON_RESET_N(por_n),
        .TEST_STRAP_PIN_IN(pad), .TEST_STRAP_PIN_DATA(data),
        .TEST_STRAP_PIN_OUT(dout), .TEST_STRAP_PIN_OE(oe),
        .TEST_MODE_SELECT(sel), .TEST_MODE(mode), .CONFIG_START(start),
        .CONFIG_ACTIVE(act));
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    // Reset, release, then move pin data so the pads change after sampling
    task boot(input rtss_strap_type s);
        int n;
        @(posedge clk);
        hold <= 1'b1;
        pull <= s;
        data <= 8'hA5;
        repeat (8) @(posedge clk);
        #1;
        `CHK("oe", 8'h00, oe)
        `CHK("act", 1'b0, act)
        `CHK("dout", 8'h00, dout)
        `CHK("sel", 8'h00, sel)
        `CHK("mode", 1'b0, mode)
        `CHK("start", 1'b0, start)
        @(posedge clk);
        hold <= 1'b0;
        for (n = 0; n < 40 && start !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        `CHK("start", 1'b1, start)
        `CHK("oe", 8'hFF, oe)
        `CHK("sel", s, sel)
        `CHK("mode", |s, mode)
        @(posedge clk);
        data <= 8'h5A;
        repeat (4) @(posedge clk);
        #1;
        `CHK("sel", s, sel)
        `CHK("dout", 8'h5A, dout)
        $display("boot with straps %h done", s);
    endtask : boot
    // A one-clock dip on the reset pad must not restart the sequence
    task glitch_ignored;
        int n;
        @(posedge clk);
        hold <= 1'b1;
        @(posedge clk);
        hold <= 1'b0;
        for (n = 0; n < 24; n++) begin
            @(posedge clk);
            #1;
            `CHK("act", 1'b1, act)
            `CHK("start", 1'b0, start)
        end
        `CHK("sel", 8'h7E, sel)
        $display("short reset dip ignored");
    endtask : glitch_ignored
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        boot(8'h00);
        boot(8'h81);
        boot(8'h7E);
        glitch_ignored();
        print_verdict();
    end
    // Three boots and a reset dip take under 200 cycles
    initial begin
        repeat (400) @(posedge clk);
        error_cnt++;
        print_verdict();
    end
endmodule : rtss_tb_top
bind rtss_top rtss_checker u_chk (.CLK(CLK), .RST(RST),
    .POWER_ON_RESET_N(POWER_ON_RESET_N),
    .TEST_STRAP_PIN_OE(TEST_STRAP_PIN_OE),
    .TEST_STRAP_PIN_OUT(TEST_STRAP_PIN_OUT), .TEST_MODE(TEST_MODE),
    .TEST_MODE_SELECT(TEST_MODE_SELECT), .CONFIG_START(CONFIG_START),
    .CONFIG_ACTIVE(CONFIG_ACTIVE));
